// ===== rtl/tv_mcu_interrupt_unit.v
// interrupt unit: request flags, enable/priority registers, poll and vector logic
// assumes the core supplies a sample strobe per machine cycle, instruction end
// and final-cycle indications, and performs the long call it is handed
`include "tv_irq_map.vh"
`default_nettype none

module tv_mcu_interrupt_unit (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // avalon-mm register slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // machine cycle timing from the core
  input wire i_sample_phase,
  input wire i_last_cycle,
  input wire i_instr_end,
  input wire i_return_from_irq,
  input wire i_core_reg_access,
  // request sources
  input wire i_ext_request_zero,
  input wire i_ext_request_one,
  input wire i_timer_zero_ovf,
  input wire i_timer_one_ovf,
  input wire i_serial_status_load,
  input wire [7:0] i_serial_status_reg,
  input wire i_caption_set,
  input wire i_busy_set,
  // long call request to the core
  output reg o_long_call,
  output reg [15:0] o_vector,
  output reg o_call_level_hi,
  output reg [1:0] o_in_progress
);

  // ==================================================
  // source order inside a level: index 0 polls first
  localparam SRC_EXT0 = 0;
  localparam SRC_SER = 1;
  localparam SRC_TMR0 = 2;
  localparam SRC_EXT1 = 3;
  localparam SRC_BUSY = 4;
  localparam SRC_TMR1 = 5;
  localparam SRC_CAP = 6;
  localparam NSRC = 7;

  // registers seen by software
  reg [7:0] enable_reg_a_ff;
  reg [7:0] enable_reg_b_ff;
  reg [7:0] priority_reg_a_ff;
  reg [7:0] request_flag_reg_ff;
  reg [7:0] serial_control_reg_ff;

  // poll state
  reg [NSRC-1:0] sample_ff;
  reg inprog_lo_ff;
  reg inprog_hi_ff;
  reg holdoff_ff;

  // synchronised pins
  wire [1:0] ext_sync;

  // combinational helpers
  wire bus_req;
  wire bus_ack;
  wire wr_en;
  wire touch_ctrl_bus;
  wire touch_ctrl;
  wire serial_status_valid;
  wire global_irq_gate;
  wire [NSRC-1:0] raw_flags;
  wire [NSRC-1:0] src_enable;
  wire [NSRC-1:0] src_prio;
  wire [NSRC-1:0] req_hi;
  wire [NSRC-1:0] req_lo;
  wire take_hi;
  wire take_lo;
  wire blocked;
  wire go_call;
  wire end_return_from_irq;
  reg [2:0] win_hi;
  reg [2:0] win_lo;
  reg [2:0] win_idx;
  reg [15:0] win_vec;
  reg [31:0] rd_mux;
  integer i;

  // ==================================================
  // external pins come from outside the clock domain
  irq_sync2 #(
    .W(2)
  ) u_ext_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_ext_request_one, i_ext_request_zero}),
    .o_sync(ext_sync)
  );

  // ==================================================
  // bus handshake: one wait state, then a single acknowledge cycle
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_ack = bus_req & ~o_avs_waitrequest;
  assign wr_en = i_avs_write & bus_ack & i_avs_byteenable[0];

  // any access to enable or priority registers holds vectoring off
  assign touch_ctrl_bus = bus_ack & (i_avs_address == `OFS_ENABLE_REG_A ||
                                     i_avs_address == `OFS_ENABLE_REG_B ||
                                     i_avs_address == `OFS_PRIORITY_REG_A ||
                                     i_avs_address == `OFS_PRIORITY_REG_B);
  assign touch_ctrl = touch_ctrl_bus | i_core_reg_access | i_return_from_irq;

  // waitrequest drops for exactly one cycle per request
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (bus_req && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // ==================================================
  // read data mux; unmapped words and reserved bits read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      `OFS_ENABLE_REG_A: rd_mux[7:0] = enable_reg_a_ff;
      `OFS_ENABLE_REG_B: rd_mux[7:0] = enable_reg_b_ff;
      `OFS_PRIORITY_REG_A: rd_mux[7:0] = priority_reg_a_ff;
      `OFS_PRIORITY_REG_B: rd_mux[7:0] = `MASK_REG_B;
      `OFS_REQUEST_FLAG_REG: rd_mux[7:0] = request_flag_reg_ff;
      `OFS_SERIAL_CONTROL_REG: rd_mux[7:0] = serial_control_reg_ff;
      `OFS_IRQ_STATUS_REG: begin
        rd_mux[`BIT_STAT_INPROG_LO] = inprog_lo_ff;
        rd_mux[`BIT_STAT_INPROG_HI] = inprog_hi_ff;
        rd_mux[`BIT_STAT_HOLDOFF] = holdoff_ff;
        rd_mux[14:8] = sample_ff;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is registered together with the drop of waitrequest
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= rd_mux;
    end
  end

  // ==================================================
  // enable and priority registers, byte lane 0 only
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      enable_reg_a_ff <= `RST_ENABLE_REG_A;
      enable_reg_b_ff <= `RST_ENABLE_REG_B;
      priority_reg_a_ff <= `RST_PRIORITY_REG_A;
    end else if (wr_en) begin
      if (i_avs_address == `OFS_ENABLE_REG_A) begin
        enable_reg_a_ff <= i_avs_writedata[7:0] & `MASK_REG_A;
      end
      if (i_avs_address == `OFS_ENABLE_REG_B) begin
        enable_reg_b_ff <= i_avs_writedata[7:0] & `MASK_REG_B;
      end
      if (i_avs_address == `OFS_PRIORITY_REG_A) begin
        priority_reg_a_ff <= i_avs_writedata[7:0] & `MASK_REG_A;
      end
    end
  end

  // ==================================================
  // caption and busy flags: hardware sets, software writes zero to clear;
  // a set in the clearing cycle wins so no event is lost
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      request_flag_reg_ff <= `RST_REQUEST_FLAG_REG;
    end else begin
      if (wr_en && i_avs_address == `OFS_REQUEST_FLAG_REG) begin
        request_flag_reg_ff <= i_avs_writedata[7:0] & `MASK_REG_B;
      end
      if (i_caption_set) begin
        request_flag_reg_ff[`BIT_CAPTION] <= 1'b1;
      end
      if (i_busy_set) begin
        request_flag_reg_ff[`BIT_BUSY] <= 1'b1;
      end
    end
  end

  // ==================================================
  // serial flag: set when a valid status code is loaded
  assign serial_status_valid = ((i_serial_status_reg & `SERIAL_STATUS_LOW_MASK) == 8'h00) &&
                               (i_serial_status_reg != `SERIAL_STATUS_IDLE);

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      serial_control_reg_ff <= `RST_SERIAL_CONTROL_REG;
    end else begin
      if (wr_en && i_avs_address == `OFS_SERIAL_CONTROL_REG) begin
        serial_control_reg_ff <= i_avs_writedata[7:0];
      end
      if (i_serial_status_load && serial_status_valid) begin
        serial_control_reg_ff[`BIT_SERIAL_IRQ_FLAG] <= 1'b1;
      end
    end
  end

  // ==================================================
  // flags, enables and levels gathered in poll order
  assign raw_flags[SRC_EXT0] = ext_sync[0];
  assign raw_flags[SRC_SER] = serial_control_reg_ff[`BIT_SERIAL_IRQ_FLAG];
  assign raw_flags[SRC_TMR0] = i_timer_zero_ovf;
  assign raw_flags[SRC_EXT1] = ext_sync[1];
  assign raw_flags[SRC_BUSY] = request_flag_reg_ff[`BIT_BUSY];
  assign raw_flags[SRC_TMR1] = i_timer_one_ovf;
  assign raw_flags[SRC_CAP] = request_flag_reg_ff[`BIT_CAPTION];

  // per-source enables, one bit each
  assign src_enable[SRC_EXT0] = enable_reg_a_ff[`BIT_EXT_ZERO];
  assign src_enable[SRC_SER] = enable_reg_a_ff[`BIT_SERIAL];
  assign src_enable[SRC_TMR0] = enable_reg_a_ff[`BIT_TIMER_ZERO];
  assign src_enable[SRC_EXT1] = enable_reg_a_ff[`BIT_EXT_ONE];
  assign src_enable[SRC_BUSY] = enable_reg_b_ff[`BIT_BUSY];
  assign src_enable[SRC_TMR1] = enable_reg_a_ff[`BIT_TIMER_ONE];
  assign src_enable[SRC_CAP] = enable_reg_b_ff[`BIT_CAPTION];
  assign global_irq_gate = enable_reg_a_ff[`BIT_GLOBAL_IRQ_GATE];

  assign src_prio[SRC_EXT0] = priority_reg_a_ff[`BIT_EXT_ZERO];
  assign src_prio[SRC_SER] = priority_reg_a_ff[`BIT_SERIAL];
  assign src_prio[SRC_TMR0] = priority_reg_a_ff[`BIT_TIMER_ZERO];
  assign src_prio[SRC_EXT1] = priority_reg_a_ff[`BIT_EXT_ONE];
  assign src_prio[SRC_BUSY] = 1'b1;
  assign src_prio[SRC_TMR1] = priority_reg_a_ff[`BIT_TIMER_ONE];
  assign src_prio[SRC_CAP] = 1'b1;

  // ==================================================
  // sample point: flags captured at each strobe, polled at the next one;
  // samples are overwritten every cycle so a denied request is forgotten
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      sample_ff <= {NSRC{1'b0}};
    end else if (i_sample_phase) begin
      sample_ff <= raw_flags;
    end
  end

  // per-level requests from last samples, gated by enables
  assign req_hi = sample_ff & src_enable & src_prio & {NSRC{global_irq_gate}};
  assign req_lo = sample_ff & src_enable & ~src_prio & {NSRC{global_irq_gate}};

  // fixed order inside each level: lowest index wins
  always @* begin
    win_hi = 3'd0;
    win_lo = 3'd0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (req_hi[i]) begin
        win_hi = i[2:0];
      end
      if (req_lo[i]) begin
        win_lo = i[2:0];
      end
    end
  end

  // higher level first; a level may not nest into itself or above
  assign take_hi = (|req_hi) & ~inprog_hi_ff;
  assign take_lo = ~take_hi & (|req_lo) & ~inprog_hi_ff & ~inprog_lo_ff;

  // ==================================================
  // vector table
  always @* begin
    win_idx = take_hi ? win_hi : win_lo;
    case (win_idx)
      3'd0: win_vec = `VEC_EXT_ZERO;
      3'd1: win_vec = `VEC_SERIAL;
      3'd2: win_vec = `VEC_TIMER_ZERO;
      3'd3: win_vec = `VEC_EXT_ONE;
      3'd4: win_vec = `VEC_BUSY;
      3'd5: win_vec = `VEC_TIMER_ONE;
      3'd6: win_vec = `VEC_CAPTION;
      default: win_vec = `VEC_EXT_ZERO;
    endcase
  end

  // ==================================================
  // hold-off: armed by a return or control access, released by the end
  // of a later instruction; set wins when both meet in one cycle
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      holdoff_ff <= 1'b0;
    end else if (touch_ctrl) begin
      holdoff_ff <= 1'b1;
    end else if (i_instr_end) begin
      holdoff_ff <= 1'b0;
    end
  end

  // conservative: the releasing instruction's own final cycle is still held
  assign blocked = touch_ctrl | holdoff_ff;
  assign go_call = i_sample_phase & i_last_cycle & ~blocked & (take_hi | take_lo);
  assign end_return_from_irq = i_instr_end & i_return_from_irq;

  // ==================================================
  // in-progress levels; a plain return is invisible here and leaves them set
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      inprog_lo_ff <= 1'b0;
      inprog_hi_ff <= 1'b0;
    end else if (go_call) begin
      if (take_hi) begin
        inprog_hi_ff <= 1'b1;
      end else begin
        inprog_lo_ff <= 1'b1;
      end
    end else if (end_return_from_irq) begin
      if (inprog_hi_ff) begin
        inprog_hi_ff <= 1'b0;
      end else begin
        inprog_lo_ff <= 1'b0;
      end
    end
  end

  // ==================================================
  // call request to the core: pc push only, status word is not saved
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_long_call <= 1'b0;
      o_vector <= 16'h0000;
      o_call_level_hi <= 1'b0;
    end else begin
      o_long_call <= go_call;
      if (go_call) begin
        o_vector <= win_vec;
        o_call_level_hi <= take_hi;
      end
    end
  end

  // in-progress state mirrored out for the core
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_in_progress <= 2'b00;
    end else begin
      o_in_progress <= {inprog_hi_ff, inprog_lo_ff};
    end
  end

endmodule // tv_mcu_interrupt_unit

`default_nettype wire

// ===== rtl/tv_irq_map.vh
// offsets, field positions, reset values and vectors of the interrupt unit
// assumes byte addressing on a 32-bit Avalon-MM slave, one register per word
`ifndef TV_IRQ_MAP_VH
`define TV_IRQ_MAP_VH

// ==================================================
// register byte offsets
`define OFS_ENABLE_REG_A 8'h00
`define OFS_ENABLE_REG_B 8'h04
`define OFS_PRIORITY_REG_A 8'h08
`define OFS_PRIORITY_REG_B 8'h0C
`define OFS_REQUEST_FLAG_REG 8'h10
`define OFS_SERIAL_CONTROL_REG 8'h14
`define OFS_IRQ_STATUS_REG 8'h18

// ==================================================
// field positions, register a (enable and priority share the layout)
`define BIT_GLOBAL_IRQ_GATE 7
`define BIT_SERIAL 5
`define BIT_TIMER_ONE 3
`define BIT_EXT_ONE 2
`define BIT_TIMER_ZERO 1
`define BIT_EXT_ZERO 0
// field positions, register b and request flag register
`define BIT_CAPTION 6
`define BIT_BUSY 5
// serial control register
`define BIT_SERIAL_IRQ_FLAG 3
// status register
`define BIT_STAT_INPROG_LO 0
`define BIT_STAT_INPROG_HI 1
`define BIT_STAT_HOLDOFF 2

// ==================================================
// reset values
`define RST_ENABLE_REG_A 8'h00
`define RST_ENABLE_REG_B 8'h00
`define RST_PRIORITY_REG_A 8'h00
`define RST_REQUEST_FLAG_REG 8'h00
`define RST_SERIAL_CONTROL_REG 8'h00
// writable bits of the register a and register b layouts; serial control is written in full
`define MASK_REG_A 8'hAF
`define MASK_REG_B 8'h60

// ==================================================
// serial status: low three bits are always zero in a valid code
`define SERIAL_STATUS_LOW_MASK 8'h07
`define SERIAL_STATUS_IDLE 8'hF8

// ==================================================
// service vectors
`define VEC_EXT_ZERO 16'h0003
`define VEC_TIMER_ZERO 16'h000B
`define VEC_EXT_ONE 16'h0013
`define VEC_TIMER_ONE 16'h001B
`define VEC_SERIAL 16'h002B
`define VEC_BUSY 16'h0063
`define VEC_CAPTION 16'h006B

`endif

// ===== rtl/irq_sync2.v
// two-stage synchroniser for a group of asynchronous levels
// assumes the inputs are quasi-static levels, not single-cycle pulses
`default_nettype none

module irq_sync2 #(
  parameter W = 2
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // asynchronous levels in
  input wire [W-1:0] i_async,
  // synchronised levels out
  output reg [W-1:0] o_sync
);

  reg [W-1:0] meta_ff;

  // ==================================================
  // first stage feeds only the second stage
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      meta_ff <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_ff <= i_async;
      o_sync <= meta_ff;
    end
  end

endmodule // irq_sync2

`default_nettype wire

// ===== dv/irq_monitor.sv
// port checks for the interrupt unit: bus answer, call pulse, levels
// assumes a bind into tv_mcu_interrupt_unit on one core clock
`include "tv_irq_map.vh"
`default_nettype none
module irq_monitor (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // bus and core timing
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_sample_phase,
  input wire logic i_last_cycle,
  input wire logic i_instr_end,
  input wire logic i_return_from_irq,
  // call outputs
  input wire logic o_long_call,
  input wire logic [15:0] o_vector,
  input wire logic o_call_level_hi,
  input wire logic [1:0] o_in_progress
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================
  // single domain, reset disables every check
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_call;
    o_long_call;
  endsequence
  sequence s_ret_done;
    i_instr_end && i_return_from_irq;
  endsequence
  a_call_pulse: assert property (s_call |=> !o_long_call)
    else $error("call pulse longer than one cycle");
  a_call_final: assert property (s_call |-> $past(i_sample_phase) && $past(i_last_cycle))
    else $error("call outside final cycle decision");
  a_vector_legal: assert property (s_call |-> o_vector inside {`VEC_EXT_ZERO, `VEC_TIMER_ZERO,
    `VEC_EXT_ONE, `VEC_TIMER_ONE, `VEC_SERIAL, `VEC_BUSY, `VEC_CAPTION}) else $error("bad vector");
  a_vector_hold: assert property (!o_long_call |-> $stable(o_vector))
    else $error("vector moved without a call");
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus access not answered in one cycle");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_inprog_set: assert property (s_call |-> ##[1:2] o_in_progress[o_call_level_hi])
    else $error("in progress not set after call");
  a_hi_no_nest: assert property (o_in_progress[1] |-> !o_long_call)
    else $error("call while high level in progress");
  a_ret_clears: assert property (s_ret_done and o_in_progress == 2'b01 |-> ##[1:3] o_in_progress == 2'b00)
    else $error("return left low level in progress");
  a_ret_holdoff: assert property (s_ret_done |=> !o_long_call [*6])
    else $error("call right after return");
  a_reset_idle: assert property ($fell(i_rst) |-> o_in_progress == 2'b00 && !o_long_call)
    else $error("level in progress after reset");
endmodule // irq_monitor
`default_nettype wire

// ===== dv/core_model.sv
// behavioural core: four-clock machine cycles, instructions of one and two cycles
// assumes the bench picks the kind of the next instruction through i_kind
`default_nettype none
module core_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // 0 plain, 1 return from irq, 2 register access
  input wire logic [1:0] i_kind,
  // timing to the interrupt unit
  output logic o_sample_phase,
  output logic o_last_cycle,
  output logic o_instr_end,
  output logic o_return_from_irq,
  output logic o_core_reg_access
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_ff;
  logic mc_ff;
  logic two_ff;
  logic [1:0] kind_ff;
  // ==================================================
  // alternate lengths so the unit sees non-final cycles too
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phase_ff <= 2'h0;
      mc_ff <= 1'b0;
      two_ff <= 1'b0;
      kind_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      if (phase_ff == 2'h3) begin
        mc_ff <= (mc_ff == two_ff) ? 1'b0 : 1'b1;
        if (mc_ff == two_ff) begin
          two_ff <= ~two_ff;
          kind_ff <= i_kind; // kind latched whole instruction
        end
      end
    end
  end
  // sample and end strobes derived from the phase counter, last cycle and kind levels from mc_ff, two_ff and kind_ff
  assign o_last_cycle = (mc_ff == two_ff);
  assign o_sample_phase = (phase_ff == 2'h2) && !i_rst;
  assign o_instr_end = o_last_cycle && (phase_ff == 2'h3) && !i_rst;
  assign o_return_from_irq = (kind_ff == 2'h1);
  assign o_core_reg_access = (kind_ff == 2'h2);
endmodule // core_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench: registers, vectors, ordering, nesting, gating
// assumes the core model drives the unit's machine cycle strobes
`include "tv_irq_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic ext0 = 1'b0, ext1 = 1'b0, tmr0 = 1'b0, tmr1 = 1'b0;
  logic ss_load = 1'b0, cap_set = 1'b0, busy_set = 1'b0;
  logic [7:0] ss_code = 8'h00;
  logic [1:0] kind = 2'h0;
  logic [6:0] on = 7'h00;
  logic [31:0] q;
  wire [31:0] rdata;
  wire waitreq, samp, last, iend, ret, racc, call, lvl;
  wire [15:0] vec;
  wire [1:0] inprog;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // vectors in poll order: ext0 serial tmr0 ext1 busy tmr1 caption
  logic [15:0] vtab [7] = '{`VEC_EXT_ZERO, `VEC_SERIAL, `VEC_TIMER_ZERO, `VEC_EXT_ONE,
    `VEC_BUSY, `VEC_TIMER_ONE, `VEC_CAPTION};
  // ==================================================
  // clock and hang guard
  always #2.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  tv_mcu_interrupt_unit tv_mcu_interrupt_unit_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_sample_phase(samp), .i_last_cycle(last), .i_instr_end(iend), .i_return_from_irq(ret),
    .i_core_reg_access(racc), .i_ext_request_zero(ext0), .i_ext_request_one(ext1),
    .i_timer_zero_ovf(tmr0), .i_timer_one_ovf(tmr1), .i_serial_status_load(ss_load),
    .i_serial_status_reg(ss_code), .i_caption_set(cap_set), .i_busy_set(busy_set),
    .o_long_call(call), .o_vector(vec), .o_call_level_hi(lvl), .o_in_progress(inprog));
  core_model core_model_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_kind(kind),
    .o_sample_phase(samp), .o_last_cycle(last), .o_instr_end(iend),
    .o_return_from_irq(ret), .o_core_reg_access(racc));
  // ==================================================
  // shared tasks
  task give_verdict;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk({31'h0, waitreq}, 32'h0);
    @(posedge i_core_clk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task wait_call(input logic [15:0] v);
    int n;
    n = 0;
    while (call !== 1'b1 && n < 400) begin
      @(posedge i_core_clk);
      n++;
    end
    chk({31'h0, call}, 32'h1);
    chk({16'h0, vec}, {16'h0, v});
  endtask
  task expect_none(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge i_core_clk);
      if (call === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0);
  endtask
  // raise or clear one source; software clears the flag bits itself
  task src(input int k, input logic v);
    on[k] = v;
    case (k)
      0: ext0 <= v;
      2: tmr0 <= v;
      3: ext1 <= v;
      5: tmr1 <= v;
      1: if (v) begin
        ss_code <= 8'h08;
        ss_load <= 1'b1;
        @(posedge i_core_clk);
        ss_load <= 1'b0;
      end else bus(1'b1, `OFS_SERIAL_CONTROL_REG, 32'h0);
      4: if (v) begin
        busy_set <= 1'b1;
        @(posedge i_core_clk);
        busy_set <= 1'b0;
      end else bus(1'b1, `OFS_REQUEST_FLAG_REG, {25'h0, on[6], 6'h0});
      default: if (v) begin
        cap_set <= 1'b1;
        @(posedge i_core_clk);
        cap_set <= 1'b0;
      end else bus(1'b1, `OFS_REQUEST_FLAG_REG, {26'h0, on[4], 5'h0});
    endcase
  endtask
  // next instruction is a return; wait until it ends
  task do_ret;
    int n;
    n = 0;
    kind <= 2'h1;
    while (ret !== 1'b1 && n < 50) begin
      @(posedge i_core_clk);
      n++;
    end
    kind <= 2'h0;
    while (!(iend === 1'b1 && ret === 1'b1) && n < 100) begin
      @(posedge i_core_clk);
      n++;
    end
    chk({31'h0, iend & ret}, 32'h1);
    @(posedge i_core_clk);
  endtask
  // ==================================================
  // scenarios
  task t_regs;
    rd_chk(`OFS_ENABLE_REG_A, 32'h0);
    rd_chk(`OFS_ENABLE_REG_B, 32'h0);
    rd_chk(`OFS_PRIORITY_REG_A, 32'h0);
    rd_chk(`OFS_REQUEST_FLAG_REG, 32'h0);
    rd_chk(`OFS_IRQ_STATUS_REG, 32'h0);
    bus(1'b1, `OFS_PRIORITY_REG_B, 32'h0);
    rd_chk(`OFS_PRIORITY_REG_B, 32'h60);
    bus(1'b1, `OFS_ENABLE_REG_A, 32'hFF);
    rd_chk(`OFS_ENABLE_REG_A, 32'hAF);
    bus(1'b1, 8'h1C, 32'hFF);
    rd_chk(8'h1C, 32'h0);
    bus(1'b1, `OFS_ENABLE_REG_A, 32'h0);
  endtask
  // idle code and nonzero low bits are not valid status codes
  task t_serial;
    logic [7:0] c [3] = '{8'hF8, 8'h09, 8'h00};
    for (int i = 0; i < 3; i++) begin
      ss_code <= c[i];
      ss_load <= 1'b1;
      @(posedge i_core_clk);
      ss_load <= 1'b0;
      @(posedge i_core_clk);
      rd_chk(`OFS_SERIAL_CONTROL_REG, (i == 2) ? 32'h8 : 32'h0);
    end
    bus(1'b1, `OFS_SERIAL_CONTROL_REG, 32'h0);
  endtask
  task t_vectors;
    bus(1'b1, `OFS_ENABLE_REG_A, 32'hAF);
    bus(1'b1, `OFS_ENABLE_REG_B, 32'h60);
    for (int k = 0; k < 7; k++) begin
      src(k, 1'b1);
      wait_call(vtab[k]);
      chk({31'h0, lvl}, (k == 4 || k == 6) ? 32'h1 : 32'h0);
      src(k, 1'b0);
      do_ret();
      repeat (3) @(posedge i_core_clk);
      chk({30'h0, inprog}, 32'h0);
    end
  endtask
  // all seven at once: level first, then poll order
  task t_order;
    int ord [7] = '{4, 6, 0, 1, 2, 3, 5};
    {ext0, ext1, tmr0, tmr1} <= 4'hF;
    {ss_load, cap_set, busy_set} <= 3'h7;
    ss_code <= 8'h08;
    on = 7'h7F;
    @(posedge i_core_clk);
    {ss_load, cap_set, busy_set} <= 3'h0;
    for (int k = 0; k < 7; k++) begin
      wait_call(vtab[ord[k]]);
      src(ord[k], 1'b0);
      do_ret();
    end
  endtask
  // high preempts low; a dropped blocked request is forgotten
  task t_nest;
    src(0, 1'b1);
    wait_call(`VEC_EXT_ZERO);
    src(0, 1'b0);
    src(5, 1'b1);
    src(3, 1'b1);
    repeat (20) @(posedge i_core_clk);
    src(3, 1'b0);
    src(6, 1'b1);
    wait_call(`VEC_CAPTION);
    repeat (3) @(posedge i_core_clk);
    chk({30'h0, inprog}, 32'h3);
    src(6, 1'b0);
    do_ret();
    repeat (3) @(posedge i_core_clk);
    chk({30'h0, inprog}, 32'h1);
    do_ret();
    wait_call(`VEC_TIMER_ONE);
    src(5, 1'b0);
    do_ret();
  endtask
  // gate and enable, then the low level stays busy until a return from irq
  task t_plain;
    bus(1'b1, `OFS_ENABLE_REG_A, 32'h2F);
    src(0, 1'b1);
    expect_none(40);
    bus(1'b1, `OFS_ENABLE_REG_A, 32'hAE);
    expect_none(40);
    bus(1'b1, `OFS_ENABLE_REG_A, 32'hAF);
    wait_call(`VEC_EXT_ZERO);
    src(0, 1'b0);
    src(5, 1'b1);
    expect_none(60);
    do_ret();
    wait_call(`VEC_TIMER_ONE);
    src(5, 1'b0);
    do_ret();
  endtask
  // core access to control registers arms the hold-off; a later instruction frees it
  task t_hold;
    int n;
    n = 0;
    kind <= 2'h2;
    while (racc !== 1'b1 && n < 50) begin
      @(posedge i_core_clk);
      n++;
    end
    kind <= 2'h0;
    rd_chk(`OFS_IRQ_STATUS_REG, 32'h4);
    repeat (30) @(posedge i_core_clk);
    rd_chk(`OFS_IRQ_STATUS_REG, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    t_regs();
    t_serial();
    t_vectors();
    t_order();
    t_nest();
    t_plain();
    t_hold();
    give_verdict();
  end
endmodule // tb
bind tv_mcu_interrupt_unit irq_monitor irq_monitor_i (.i_core_clk, .i_rst, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_sample_phase, .i_last_cycle, .i_instr_end, .i_return_from_irq,
  .o_long_call, .o_vector, .o_call_level_hi, .o_in_progress);
`default_nettype wire
